/* src/aar_autoneg_regs.sv */
// Management-frame register bank: identifier, advertisement, partner ability
`timescale 1ns/100ps

// Summary of operation
// - ID2 upper six bits: read-only vendor bits
// - ID2 bits 9:4: read-only model code
// - ID2 low nibble: read-only revision code
// - Advert bit 10 pause, writable, resets zero
// - Advert bit 9 T4, writable, resets zero
// - TX full-duplex loads duplex AND hundred straps
// - TX half-duplex loads hundred strap, writable
// - 10 full-duplex loads duplex AND ten straps
// - 10 half-duplex loads ten strap, writable
// - Selector writable, resets to 802.3 code
// - Advert bit 13 remote fault, writable, zero
// - Partner bit 15 reports next page
// - Partner bit 14 reports acknowledge
// - Partner bit 10 reports pause
// - Partner bits 9:5 report technology abilities
// - Partner low five bits report selector
// - Page received latches on three identical words
// - Negotiation enable starts with advertised abilities
module aar_autoneg_regs #(
  parameter logic [5:0] VENDOR_ID_BITS = 6'h2a, // Arbitrary value
  parameter logic [5:0] MODEL_CODE     = 6'h11, // Arbitrary value
  parameter logic [3:0] REVISION_CODE  = 4'h1   // Arbitrary value
) (
  // Clock and reset
  input  wire logic            mclk_i,
  input  wire logic            rst_i,
  // Configuration straps and port address
  input  wire logic            full_duplex_strap_i,
  input  wire logic            speed100_strap_i,
  input  wire logic            speed10_strap_i,
  input  wire logic            aneg_enable_strap_i,
  input  wire logic [4:0]      phy_addr_i,
  // Serial management pins
  input  wire logic            mdc_i,
  input  wire logic            mdio_i,
  output logic                 mdio_o,
  output logic                 mdio_oe_o,
  // Negotiation engine side
  input  aar_pkg::aar_lcw_t    lcw_i,
  output logic                 aneg_enable_o,
  output logic                 aneg_start_o,
  output logic [15:0]          adv_word_o
);
  import aar_pkg::*;

  aar_regs_t q;
  aar_regs_t d;

  // ----------------------------------------------------------------
  // Read data selection
  // ----------------------------------------------------------------
  function automatic logic [15:0] rd_word(input aar_regs_t s, input logic [4:0] ofs);
    logic [15:0] r;
    r = 16'h0000;
    case (ofs)
      AAR_OFS_CTRL: r[AAR_CTRL_ANEG_BIT] = s.aneg_en;
      AAR_OFS_ID2:  r = {VENDOR_ID_BITS, MODEL_CODE, REVISION_CODE};
      AAR_OFS_ADV:  r = s.adv;
      AAR_OFS_LPA:  r = s.lpa;
      AAR_OFS_EXP: begin
        r[AAR_EXP_PAGE_RX] = s.page_rx;
        r[AAR_EXP_LP_ANEG] = s.lp_aneg;
      end
      default:      r = 16'h0000;
    endcase
    return r;
  endfunction

  logic        mdc_rise;
  logic        is_read;
  logic        is_write;
  logic [15:0] wr_word;
  logic        rd_exp;
  logic        page_set;
  logic [15:0] rd_sel;

  assign mdc_rise = mdc_i & ~q.mdc;
  assign is_read  = (q.op == AAR_OP_READ);
  assign is_write = (q.op == AAR_OP_WRITE);
  assign wr_word  = {q.sh[14:0], mdio_i};
  assign rd_sel   = rd_word(q, q.addr[4:0]);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    d          = q;
    d.mdc      = mdc_i;
    d.an_start = 1'b0;
    rd_exp     = 1'b0;
    page_set   = 1'b0;

    // Straps are caught on the first edge after reset release
    if (!q.loaded) begin
      d.loaded             = 1'b1;
      d.aneg_en            = aneg_enable_strap_i;
      d.adv[AAR_ADV_TXFD]  = full_duplex_strap_i & speed100_strap_i;
      d.adv[AAR_ADV_TX]    = speed100_strap_i;
      d.adv[AAR_ADV_10FD]  = full_duplex_strap_i & speed10_strap_i;
      d.adv[AAR_ADV_10]    = speed10_strap_i;
      d.an_start           = aneg_enable_strap_i;
    end

    if (mdc_rise) begin
      case (q.st)
        AAR_S_PRE: begin
          // Suppressed preamble is not accepted: a full run is needed
          if (mdio_i) begin
            if (q.cnt != AAR_PREAMBLE_LEN) begin
              d.cnt = q.cnt + 6'd1;
            end
          end else if (q.cnt == AAR_PREAMBLE_LEN) begin
            d.st = AAR_S_START;
          end else begin
            d.cnt = 6'd0;
          end
        end
        AAR_S_START: begin
          d.cnt = 6'd0;
          d.st  = mdio_i ? AAR_S_OP : AAR_S_PRE;
        end
        AAR_S_OP: begin
          d.op  = {q.op[0], mdio_i};
          d.cnt = q.cnt + 6'd1;
          if (q.cnt == 6'd1) begin
            d.cnt = 6'd0;
            d.st  = AAR_S_ADDR;
          end
        end
        AAR_S_ADDR: begin
          d.addr = {q.addr[8:0], mdio_i};
          d.cnt  = q.cnt + 6'd1;
          if (q.cnt == AAR_ADDR_BITS - 6'd1) begin
            d.cnt = 6'd0;
            d.hit = ({q.addr[8:4], q.addr[3]} == {phy_addr_i, q.addr[3]});
            d.st  = (is_read || is_write) ? AAR_S_TA : AAR_S_PRE;
          end
        end
        AAR_S_TA: begin
          d.cnt = q.cnt + 6'd1;
          if (q.cnt == 6'd0) begin
            // Second turnaround bit is driven low by this end
            if (is_read && q.hit) begin
              d.mdio_oe = 1'b1;
              d.mdio_o  = 1'b0;
            end
          end else begin
            d.cnt = 6'd0;
            d.st  = AAR_S_DATA;
            if (is_read && q.hit) begin
              d.mdio_o = rd_sel[15];
              d.sh     = {rd_sel[14:0], 1'b0};
              rd_exp   = (q.addr[4:0] == AAR_OFS_EXP);
            end
          end
        end
        AAR_S_DATA: begin
          d.cnt = q.cnt + 6'd1;
          if (is_read) begin
            d.mdio_o = q.sh[15];
            d.sh     = {q.sh[14:0], 1'b0};
          end else begin
            d.sh = wr_word;
          end
          if (q.cnt == AAR_DATA_BITS - 6'd1) begin
            d.cnt     = 6'd0;
            d.st      = AAR_S_PRE;
            d.mdio_oe = 1'b0;
            d.mdio_o  = 1'b0;
            if (is_write && q.hit) begin
              case (q.addr[4:0])
                AAR_OFS_CTRL: begin
                  d.aneg_en = wr_word[AAR_CTRL_ANEG_BIT];
                  d.an_start = wr_word[AAR_CTRL_ANEG_BIT] & ~q.aneg_en;
                end
                AAR_OFS_ADV: begin
                  d.adv = wr_word & AAR_ADV_WR_MASK;
                  // reserved selector codes are stored as written
                end
                default: d.adv = q.adv;
              endcase
            end
          end
        end
        default: begin
          d.st      = AAR_S_PRE;
          d.cnt     = 6'd0;
          d.mdio_oe = 1'b0;
        end
      endcase
    end

    // three identical words latch the page
    if (lcw_i.valid) begin
      d.last_lcw = lcw_i.word;
      if (lcw_i.word != q.last_lcw || q.match == 2'd0) begin
        d.match = 2'd1;
      end else if (q.match != AAR_LCW_MATCHES) begin
        d.match = q.match + 2'd1;
        if (q.match == AAR_LCW_MATCHES - 2'd1) begin
          page_set = 1'b1;
          d.lpa     = lcw_i.word;
          d.lp_aneg = 1'b1;
        end
      end
    end

    // Read of the expansion word clears the latch; a new page wins
    if (page_set) begin
      d.page_rx = 1'b1;
    end else if (rd_exp) begin
      d.page_rx = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      q          <= '0;
      q.st       <= AAR_S_PRE;
      q.adv      <= AAR_ADV_RESET;
    end else begin
      q <= d;
    end
  end

  // advertised abilities go to the engine
  assign adv_word_o    = q.adv;
  assign aneg_enable_o = q.aneg_en;
  assign aneg_start_o  = q.an_start;
  assign mdio_o        = q.mdio_o;
  assign mdio_oe_o     = q.mdio_oe;

endmodule

/* src/aar_pkg.sv */
// Package for the auto-negotiation ability register bank
package aar_pkg;

  // ----------------------------------------------------------------
  // Register offsets on the management frame
  // ----------------------------------------------------------------
  localparam logic [4:0] AAR_OFS_CTRL = 5'h00;
  localparam logic [4:0] AAR_OFS_ID2  = 5'h03;
  localparam logic [4:0] AAR_OFS_ADV  = 5'h04;
  localparam logic [4:0] AAR_OFS_LPA  = 5'h05;
  localparam logic [4:0] AAR_OFS_EXP  = 5'h06;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         AAR_CTRL_ANEG_BIT = 12;
  localparam int         AAR_ADV_RFAULT    = 13;
  localparam int         AAR_ADV_PAUSE     = 10;
  localparam int         AAR_ADV_T4        = 9;
  localparam int         AAR_ADV_TXFD      = 8;
  localparam int         AAR_ADV_TX        = 7;
  localparam int         AAR_ADV_10FD      = 6;
  localparam int         AAR_ADV_10        = 5;
  localparam int         AAR_EXP_PAGE_RX   = 1;
  localparam int         AAR_EXP_LP_ANEG   = 0;
  localparam logic [15:0] AAR_ADV_WR_MASK  = 16'h3fff;
  localparam logic [4:0] AAR_SEL_8023      = 5'h01;
  localparam logic [4:0] AAR_SEL_8029      = 5'h02;
  localparam logic [15:0] AAR_ADV_RESET    = {11'h000, AAR_SEL_8023};

  // ----------------------------------------------------------------
  // Frame field codes and cycle counts
  // ----------------------------------------------------------------
  localparam logic [1:0] AAR_OP_READ      = 2'b10;
  localparam logic [1:0] AAR_OP_WRITE     = 2'b01;
  localparam logic [5:0] AAR_PREAMBLE_LEN = 6'd32;
  localparam logic [5:0] AAR_ADDR_BITS    = 6'd10;
  localparam logic [5:0] AAR_DATA_BITS    = 6'd16;
  localparam logic [1:0] AAR_LCW_MATCHES  = 2'd3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    AAR_S_PRE   = 6'b000001,
    AAR_S_START = 6'b000010,
    AAR_S_OP    = 6'b000100,
    AAR_S_ADDR  = 6'b001000,
    AAR_S_TA    = 6'b010000,
    AAR_S_DATA  = 6'b100000
  } aar_state_t;

  // Link code word delivered by the negotiation engine
  typedef struct packed {
    logic        valid;
    logic [15:0] word;
  } aar_lcw_t;

  typedef struct packed {
    aar_state_t  st;
    logic        mdc;
    logic [5:0]  cnt;
    logic [1:0]  op;
    logic [9:0]  addr;
    logic [15:0] sh;
    logic        hit;
    logic        mdio_o;
    logic        mdio_oe;
    logic        loaded;
    logic        aneg_en;
    logic        an_start;
    logic [15:0] adv;
    logic [15:0] lpa;
    logic        page_rx;
    logic        lp_aneg;
    logic [15:0] last_lcw;
    logic [1:0]  match;
  } aar_regs_t;

endpackage

/* dv/aar_autoneg_regs_chk.sv */
// Port-level assertions for the ability register bank
`timescale 1ns/100ps
module aar_autoneg_regs_chk (
  // Clock, reset and straps
  input wire logic        mclk_i,
  input wire logic        rst_i,
  input wire logic        full_duplex_strap_i,
  input wire logic        speed100_strap_i,
  input wire logic        speed10_strap_i,
  // Watched pins
  input wire logic        mdc_i,
  input wire logic        mdio_o,
  input wire logic        mdio_oe_o,
  input wire logic        aneg_enable_o,
  input wire logic        aneg_start_o,
  input wire logic [15:0] adv_word_o
);
  import aar_pkg::*;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_strap_hi;
    !rst_i && $past(rst_i) |=> adv_word_o[8] == (full_duplex_strap_i & speed100_strap_i)
      && adv_word_o[7] == speed100_strap_i;
  endproperty
  a_strap_hi: assert property (p_strap_hi) else $error("hundred straps not loaded");
  property p_strap_lo;
    !rst_i && $past(rst_i) |=> adv_word_o[6] == (full_duplex_strap_i & speed10_strap_i)
      && adv_word_o[5] == speed10_strap_i;
  endproperty
  a_strap_lo: assert property (p_strap_lo) else $error("ten straps not loaded");
  property p_adv_rst;
    !rst_i && $past(rst_i) |=> adv_word_o[15:9] == 7'h00 && adv_word_o[4:0] == AAR_SEL_8023;
  endproperty
  a_adv_rst: assert property (p_adv_rst) else $error("advertisement reset wrong");
  property p_ta_zero;
    $rose(mdio_oe_o) |-> !mdio_o && $past(mdc_i) && !$past(mdc_i, 2);
  endproperty
  a_ta_zero: assert property (p_ta_zero) else $error("turnaround drive wrong");
  property p_mdo_hold;
    !$stable(mdio_o) |-> $past(mdc_i) && !$past(mdc_i, 2);
  endproperty
  a_mdo_hold: assert property (p_mdo_hold) else $error("read data moved between rises");
  property p_adv_quiet;
    !$stable(adv_word_o) |-> !mdio_oe_o;
  endproperty
  a_adv_quiet: assert property (p_adv_quiet) else $error("advertisement changed in read");
  property p_start_pulse;
    aneg_start_o |=> !aneg_start_o;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
  property p_start_en;
    aneg_start_o |-> ##[0:1] aneg_enable_o;
  endproperty
  a_start_en: assert property (p_start_en) else $error("start without enable");
endmodule

/* dv/aar_mgmt_master.sv */
// Station management controller model driving the serial frames
`timescale 1ns/100ps
module aar_mgmt_master (
  // Clock
  input  wire logic mclk_i,
  // Line
  input  wire logic mdio_o,
  input  wire logic mdio_oe_o,
  output logic      mdc_o,
  output wire logic line_o
);
  import aar_pkg::*;
  logic drv_en;
  logic drv_v;
  // Released line floats high through the pull-up
  assign line_o = mdio_oe_o ? mdio_o : (drv_en ? drv_v : 1'b1);
  initial begin
    mdc_o  = 1'b0;
    drv_en = 1'b0;
    drv_v  = 1'b0;
  end
  // Clock stands low outside frames; line released from turnaround on reads
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] bits;
    logic        rel;
    bits = {32'hffff_ffff, 2'b01, op, pa, ra, 2'b10, wd};
    rd   = 16'h0000;
    for (int i = 63; i >= 0; i--) begin
      rel = (op == AAR_OP_READ) && (i < 18);
      @(posedge mclk_i);
      #1;
      mdc_o  = 1'b0;
      drv_en = !rel;
      drv_v  = bits[i];
      repeat (2) @(posedge mclk_i);
      #1;
      if (rel && i < 16) rd[i] = line_o;
      mdc_o = 1'b1;
    end
    @(posedge mclk_i);
    #1;
    mdc_o  = 1'b0;
    drv_en = 1'b0;
  endtask
endmodule

/* dv/aar_autoneg_regs_bench.sv */
// Self-checking bench for the ability register bank
`timescale 1ns/100ps
module aar_autoneg_regs_bench;
  import aar_pkg::*;
  localparam logic [4:0]  PA  = 5'h05;
  localparam logic [5:0]  VID = 6'h15; // Arbitrary value
  localparam logic [5:0]  MID = 6'h0c; // Arbitrary value
  localparam logic [3:0]  RID = 4'h9;  // Arbitrary value
  localparam logic [15:0] LCW = 16'hc6a1;
  logic        mclk_i, rst_i, fd, s100, s10, an_s, mdc, mdo, mdoe, an_en, an_st;
  logic [15:0] adv, rd;
  aar_lcw_t    lcw;
  wire         line;
  int          error_cnt, check_count;
  aar_autoneg_regs #(.VENDOR_ID_BITS(VID), .MODEL_CODE(MID), .REVISION_CODE(RID)) dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .full_duplex_strap_i(fd), .speed100_strap_i(s100),
    .speed10_strap_i(s10), .aneg_enable_strap_i(an_s), .phy_addr_i(PA), .mdc_i(mdc),
    .mdio_i(line), .mdio_o(mdo), .mdio_oe_o(mdoe), .lcw_i(lcw), .aneg_enable_o(an_en),
    .aneg_start_o(an_st), .adv_word_o(adv));
  aar_mgmt_master mst (.mclk_i(mclk_i), .mdio_o(mdo), .mdio_oe_o(mdoe), .mdc_o(mdc), .line_o(line));
  always #4 mclk_i = ~mclk_i;
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic reg_wr(input logic [4:0] ra, input logic [15:0] d);
    mst.frame(AAR_OP_WRITE, PA, ra, d, rd);
  endtask
  task automatic reg_chk(input logic [4:0] ra, input logic [15:0] m, input logic [15:0] exp);
    mst.frame(AAR_OP_READ, PA, ra, 16'h0000, rd);
    check($sformatf("reg %0d", ra), rd & m, exp);
  endtask
  // Straps change only while reset is held, as on a real board
  task automatic do_reset(input logic [3:0] st);
    rst_i = 1'b1;
    {fd, s100, s10, an_s} = st;
    repeat (2) @(posedge mclk_i);
    #1;
    rst_i = 1'b0;
    repeat (2) @(posedge mclk_i);
    #1;
  endtask
  task automatic send_lcw(input logic [15:0] w);
    @(posedge mclk_i);
    #1;
    lcw = '{valid: 1'b1, word: w};
    @(posedge mclk_i);
    #1;
    lcw.valid = 1'b0;
  endtask
  task automatic stop_test();
    if (error_cnt == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge mclk_i);
    error_cnt++;
    stop_test();
  end
  initial begin
    mclk_i = 1'b0;
    lcw = '0;
    error_cnt = 0;
    check_count = 0;
    do_reset(4'b1101);
    check("adv_word_o", adv, 16'h0181);
    reg_chk(AAR_OFS_ADV, 16'hffff, 16'h0181);
    reg_chk(AAR_OFS_ID2, 16'hffff, {VID, MID, RID});
    reg_wr(AAR_OFS_ID2, 16'hffff);
    reg_chk(AAR_OFS_ID2, 16'hffff, {VID, MID, RID});
    // Selector stored as written; bits 15:14 read back zero
    reg_wr(AAR_OFS_ADV, 16'hffe2);
    reg_chk(AAR_OFS_ADV, 16'hffff, 16'h3fe2);
    check("adv_word_o", adv, 16'h3fe2);
    reg_wr(AAR_OFS_ADV, 16'h0001);
    reg_chk(AAR_OFS_ADV, 16'hffff, 16'h0001);
    mst.frame(AAR_OP_WRITE, PA + 5'h01, AAR_OFS_ADV, 16'h01e1, rd);
    reg_chk(AAR_OFS_ADV, 16'hffff, 16'h0001);
    reg_chk(AAR_OFS_LPA, 16'hffff, 16'h0000);
    repeat (2) send_lcw(LCW);
    send_lcw(16'h0021);
    repeat (2) send_lcw(LCW);
    reg_chk(AAR_OFS_LPA, 16'hffff, 16'h0000);
    send_lcw(LCW);
    reg_chk(AAR_OFS_LPA, 16'hffff, LCW);
    reg_chk(AAR_OFS_EXP, 16'h0002, 16'h0002);
    reg_chk(AAR_OFS_EXP, 16'h0002, 16'h0000);
    reg_wr(AAR_OFS_CTRL, 16'h0000);
    reg_wr(AAR_OFS_CTRL, 16'h1000);
    check("aneg_enable_o", {15'h0000, an_en}, 16'h0001);
    reg_chk(AAR_OFS_CTRL, 16'hffff, 16'h1000);
    reg_chk(5'h07, 16'hffff, 16'h0000);
    do_reset(4'b0010);
    reg_chk(AAR_OFS_ADV, 16'hffff, 16'h0021);
    stop_test();
  end
endmodule
bind aar_autoneg_regs aar_autoneg_regs_chk u_chk (
  .mclk_i(mclk_i), .rst_i(rst_i), .full_duplex_strap_i(full_duplex_strap_i),
  .speed100_strap_i(speed100_strap_i), .speed10_strap_i(speed10_strap_i), .mdc_i(mdc_i),
  .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o), .aneg_enable_o(aneg_enable_o),
  .aneg_start_o(aneg_start_o), .adv_word_o(adv_word_o));
